// *** uart_fifo_pkg.sv ***
// constants, field layouts and types for the uart fifo and dma control block
// assumes an apb master with 32-bit data and one aligned word per register
package uart_fifo_pkg;

    // register byte offsets
    localparam logic [11:0] OFF_DATA = 12'h000;
    localparam logic [11:0] OFF_FIFO_CONTROL = 12'h004;
    localparam logic [11:0] OFF_INT_STATUS = 12'h008;
    localparam logic [11:0] OFF_FIFO_STATUS = 12'h00C;

    // fifo geometry
    localparam int FIFO_DEPTH = 32;
    localparam int PTR_W = 5;
    localparam int CNT_W = 6;
    localparam logic [5:0] CNT_FULL = 6'h20;
    localparam logic [5:0] CNT_ONE = 6'h01;
    localparam logic [5:0] CNT_ZERO = 6'h00;

    // receive trigger levels by code
    localparam logic [5:0] RX_TRIG_0 = 6'h08;
    localparam logic [5:0] RX_TRIG_1 = 6'h10;
    localparam logic [5:0] RX_TRIG_2 = 6'h18;
    localparam logic [5:0] RX_TRIG_3 = 6'h1C;

    // transmit trigger levels by code
    localparam logic [5:0] TX_TRIG_0 = 6'h10;
    localparam logic [5:0] TX_TRIG_1 = 6'h08;
    localparam logic [5:0] TX_TRIG_2 = 6'h18;
    localparam logic [5:0] TX_TRIG_3 = 6'h1E;

    // fifo control field positions
    localparam int FCR_EN_BIT = 0;
    localparam int FCR_RX_FLUSH_BIT = 1;
    localparam int FCR_TX_FLUSH_BIT = 2;
    localparam int FCR_DMA_BIT = 3;

    // interrupt status field positions
    localparam int ISR_TX_BIT = 0;
    localparam int ISR_RX_BIT = 1;
    localparam int ISR_FIFO_LO_BIT = 6;
    localparam int ISR_FIFO_HI_BIT = 7;

    // fifo status field positions
    localparam int FST_TX_LSB = 0;
    localparam int FST_RX_LSB = 8;
    localparam int FST_OVR_BIT = 16;

    // fifo control register layout, bit 7 first
    typedef struct packed {
        logic [1:0] rx_trigger_select;
        logic [1:0] tx_trigger_select;
        logic dma_mode;
        logic tx_fifo_flush;
        logic rx_fifo_flush;
        logic fifo_en;
    } fifo_control_t;

    localparam fifo_control_t FIFO_CONTROL_RESET = 8'h00;

    // one character with its valid flag
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } char_t;

    localparam char_t CHAR_NONE = 9'h000;

    // rx trigger level from its code
    function automatic logic [5:0] rx_trigger_level(input logic [1:0] code);
        unique case (code)
            2'h0: rx_trigger_level = RX_TRIG_0;
            2'h1: rx_trigger_level = RX_TRIG_1;
            2'h2: rx_trigger_level = RX_TRIG_2;
            2'h3: rx_trigger_level = RX_TRIG_3;
        endcase
    endfunction

    // tx trigger level from its code
    function automatic logic [5:0] tx_trigger_level(input logic [1:0] code);
        unique case (code)
            2'h0: tx_trigger_level = TX_TRIG_0;
            2'h1: tx_trigger_level = TX_TRIG_1;
            2'h2: tx_trigger_level = TX_TRIG_2;
            2'h3: tx_trigger_level = TX_TRIG_3;
        endcase
    endfunction

endpackage

// *** char_fifo.sv ***
// character fifo with fill count, flush and a one-entry holding mode
// assumes push and pop are single-cycle strobes on pclk
`timescale 1ns/100ps
module char_fifo
    import uart_fifo_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic flush,
    input wire logic limit_one,
    // write side
    input wire logic push,
    input wire logic [7:0] push_data,
    // read side
    input wire logic pop,
    output logic [7:0] head_data,
    output logic [5:0] count,
    output logic full,
    output logic empty
);
    logic [7:0] mem [FIFO_DEPTH];
    logic [4:0] wr_ptr_reg;
    logic [4:0] rd_ptr_reg;
    logic [5:0] count_reg;
    logic do_push;
    logic do_pop;

    // a disabled fifo behaves as a single holding register
    assign full = limit_one ? (count_reg >= CNT_ONE) : (count_reg == CNT_FULL);
    assign empty = (count_reg == CNT_ZERO);
    assign count = count_reg;
    assign head_data = mem[rd_ptr_reg];
    assign do_push = push && !full;
    assign do_pop = pop && !empty;

    // storage array
    always_ff @(posedge pclk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= push_data;
        end
    end

    // pointers and count, flush wins over traffic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_reg <= 5'h00;
            rd_ptr_reg <= 5'h00;
            count_reg <= 6'h00;
        end else if (flush) begin
            wr_ptr_reg <= 5'h00;
            rd_ptr_reg <= 5'h00;
            count_reg <= 6'h00;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + 5'h01;
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_reg + 5'h01;
            end
            if (do_push && !do_pop) begin
                count_reg <= count_reg + 6'h01;
            end else if (do_pop && !do_push) begin
                count_reg <= count_reg - 6'h01;
            end
        end
    end
endmodule

// *** uart_fifo_dma_control.sv ***
// fifo control for one uart channel: apb registers, tx and rx fifos,
// dma ready outputs and fifo interrupt requests
// assumes the shifters pop and push single characters on pclk strobes
`timescale 1ns/100ps
module uart_fifo_dma_control
    import uart_fifo_pkg::*;
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // transmit shifter side
    input wire logic tx_pop,
    output uart_fifo_pkg::char_t tx_char,
    // receive shifter side
    input wire uart_fifo_pkg::char_t rx_char,
    input wire logic rx_timeout,
    // dma handshake
    output logic tx_dma_ready_n,
    output logic rx_dma_ready_n,
    // requests to the interrupt prioritiser
    output logic tx_irq_req,
    output logic rx_irq_req
);
    import uart_fifo_pkg::*;

    fifo_control_t fifo_control_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    char_t tx_char_reg;
    logic tx_dma_ready_n_reg;
    logic rx_dma_ready_n_reg;
    logic tx_irq_reg;
    logic rx_irq_reg;
    logic tx_below_reg;
    logic overrun_reg;

    logic setup;
    logic access_done;
    logic wr_done;
    logic rd_done;
    logic addr_ok;
    logic sel_data;
    logic sel_fcr;
    logic sel_isr;
    logic sel_fst;
    logic tx_flush;
    logic rx_flush;
    logic tx_push;
    logic tx_pop_ok;
    logic rx_pop;
    logic [7:0] tx_head;
    logic [7:0] rx_head;
    logic [5:0] tx_count;
    logic [5:0] rx_count;
    logic tx_full;
    logic tx_empty;
    logic rx_full;
    logic rx_empty;
    logic [5:0] tx_trig;
    logic [5:0] rx_trig;
    logic tx_below;
    logic fifo_off;
    logic [31:0] read_value;

    // bus phase decode
    assign setup = psel && !penable;
    assign access_done = psel && penable && pready_reg;
    assign wr_done = access_done && pwrite && addr_ok;
    assign rd_done = access_done && !pwrite && addr_ok;
    assign sel_data = (paddr == OFF_DATA);
    assign sel_fcr = (paddr == OFF_FIFO_CONTROL);
    assign sel_isr = (paddr == OFF_INT_STATUS);
    assign sel_fst = (paddr == OFF_FIFO_STATUS);
    assign addr_ok = sel_data || sel_fcr || sel_isr || sel_fst;

    // flush strobes come from a control write carrying the enable bit
    assign tx_flush = wr_done && sel_fcr && pwdata[FCR_EN_BIT] && pwdata[FCR_TX_FLUSH_BIT];
    assign rx_flush = wr_done && sel_fcr && pwdata[FCR_EN_BIT] && pwdata[FCR_RX_FLUSH_BIT];

    // data path strobes
    assign tx_push = wr_done && sel_data;
    assign rx_pop = rd_done && sel_data;
    assign tx_pop_ok = tx_pop && tx_char_reg.valid;

    // trigger levels and mode
    assign tx_trig = tx_trigger_level(fifo_control_reg.tx_trigger_select);
    assign rx_trig = rx_trigger_level(fifo_control_reg.rx_trigger_select);
    assign fifo_off = !fifo_control_reg.fifo_en;
    assign tx_below = fifo_off ? tx_empty : (tx_count < tx_trig);

    // transmit fifo, one entry deep while fifos are off
    char_fifo tx_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .flush(tx_flush),
        .limit_one(fifo_off),
        .push(tx_push),
        .push_data(pwdata[7:0]),
        .pop(tx_pop_ok),
        .head_data(tx_head),
        .count(tx_count),
        .full(tx_full),
        .empty(tx_empty)
    );

    // receive fifo, one entry deep while fifos are off
    char_fifo rx_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .flush(rx_flush),
        .limit_one(fifo_off),
        .push(rx_char.valid),
        .push_data(rx_char.data),
        .pop(rx_pop),
        .head_data(rx_head),
        .count(rx_count),
        .full(rx_full),
        .empty(rx_empty)
    );

    // fifo control register; enable always written, the rest only with it set
    // flush bits are strobes only, so the stored copies always read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_control_reg <= FIFO_CONTROL_RESET;
        end else begin
            fifo_control_reg.tx_fifo_flush <= 1'b0;
            fifo_control_reg.rx_fifo_flush <= 1'b0;
            if (wr_done && sel_fcr) begin
                fifo_control_reg.fifo_en <= pwdata[FCR_EN_BIT];
                if (pwdata[FCR_EN_BIT]) begin
                    fifo_control_reg.rx_trigger_select <= pwdata[7:6];
                    fifo_control_reg.tx_trigger_select <= pwdata[5:4];
                    fifo_control_reg.dma_mode <= pwdata[FCR_DMA_BIT];
                end
            end
        end
    end

    // read mux for the addressed register
    always_comb begin
        read_value = 32'h0000_0000;
        unique case (1'b1)
            sel_data: begin
                read_value[7:0] = rx_empty ? 8'h00 : rx_head;
            end
            sel_fcr: begin
                read_value[7:0] = fifo_control_reg;
            end
            sel_isr: begin
                read_value[ISR_TX_BIT] = tx_irq_reg;
                read_value[ISR_RX_BIT] = rx_irq_reg;
                read_value[ISR_FIFO_LO_BIT] = fifo_control_reg.fifo_en;
                read_value[ISR_FIFO_HI_BIT] = fifo_control_reg.fifo_en;
            end
            sel_fst: begin
                read_value[FST_TX_LSB +: CNT_W] = tx_count;
                read_value[FST_RX_LSB +: CNT_W] = rx_count;
                read_value[FST_OVR_BIT] = overrun_reg;
            end
            default: begin
                read_value = 32'h0000_0000;
            end
        endcase
    end

    // apb answer: ready in the first access cycle, error for unmapped addresses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : read_value;
            pready_reg <= 1'b1;
            pslverr_reg <= !addr_ok;
        end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // head of the tx fifo offered to the shifter, one bubble after each pop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_char_reg <= CHAR_NONE;
        end else if (tx_flush || tx_pop_ok) begin
            tx_char_reg <= CHAR_NONE;
        end else begin
            tx_char_reg.valid <= !tx_empty;
            tx_char_reg.data <= tx_head;
        end
    end

    // sticky overrun when a character meets a full rx fifo
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun_reg <= 1'b0;
        end else if (rx_char.valid && rx_full) begin
            overrun_reg <= 1'b1;
        end else if (rx_flush || (rd_done && sel_fst)) begin
            overrun_reg <= 1'b0;
        end
    end

    // transmit dma ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_dma_ready_n_reg <= 1'b0;
        end else if (fifo_off || !fifo_control_reg.dma_mode) begin
            tx_dma_ready_n_reg <= !tx_empty;
        end else if (tx_full) begin
            tx_dma_ready_n_reg <= 1'b1;
        end else if (tx_count <= tx_trig) begin
            tx_dma_ready_n_reg <= 1'b0;
        end
    end

    // receive dma ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_dma_ready_n_reg <= 1'b1;
        end else if (fifo_off || !fifo_control_reg.dma_mode) begin
            rx_dma_ready_n_reg <= rx_empty;
        end else if (rx_empty) begin
            rx_dma_ready_n_reg <= 1'b1;
        end else if ((rx_count >= rx_trig) || rx_timeout) begin
            rx_dma_ready_n_reg <= 1'b0;
        end
    end

    // rx request follows the fill against the trigger level, or follows non-empty while fifos are off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_irq_reg <= 1'b0;
        end else if (fifo_off) begin
            rx_irq_reg <= !rx_empty;
        end else begin
            rx_irq_reg <= (rx_count >= rx_trig);
        end
    end

    // tx request set on falling below trigger, or on emptying while fifos are off, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_below_reg <= 1'b0;
            tx_irq_reg <= 1'b0;
        end else begin
            tx_below_reg <= tx_below;
            if (tx_below && !tx_below_reg) begin
                tx_irq_reg <= 1'b1;
            end else if ((rd_done && sel_isr) || tx_push) begin
                tx_irq_reg <= 1'b0;
            end
        end
    end

    // outputs straight from flip-flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign tx_char = tx_char_reg;
    assign tx_dma_ready_n = tx_dma_ready_n_reg;
    assign rx_dma_ready_n = rx_dma_ready_n_reg;
    assign tx_irq_req = tx_irq_reg;
    assign rx_irq_req = rx_irq_reg;
endmodule

// *** uart_fifo_monitor.sv ***
// assertions on the ports of the uart fifo and dma control block
// assumes a bind onto uart_fifo_dma_control and shadows its fills
`timescale 1ns/100ps
module uart_fifo_monitor
    import uart_fifo_pkg::*;
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // shifters
    input wire logic tx_pop,
    input wire uart_fifo_pkg::char_t tx_char,
    input wire uart_fifo_pkg::char_t rx_char,
    // dma and requests
    input wire logic tx_dma_ready_n,
    input wire logic rx_dma_ready_n,
    input wire logic tx_irq_req,
    input wire logic rx_irq_req
);
    localparam logic [5:0] RXL [4] = '{RX_TRIG_0, RX_TRIG_1, RX_TRIG_2, RX_TRIG_3};
    localparam logic [5:0] TXL [4] = '{TX_TRIG_0, TX_TRIG_1, TX_TRIG_2, TX_TRIG_3};
    logic en, dma, acc, fw, m0, rx_lvl, tx_in, tx_out, rx_in, rx_out, isr_rd;
    logic [1:0] rxc, txc;
    logic [5:0] txn, rxn, lim, rxl, txl;
    // decode of finished transfers and of the shadow mode
    assign acc = psel && penable && pready;
    assign fw = acc && pwrite && paddr == OFF_FIFO_CONTROL;
    assign isr_rd = acc && !pwrite && paddr == OFF_INT_STATUS;
    assign m0 = !en || !dma;
    assign lim = en ? CNT_FULL : CNT_ONE;
    assign rxl = RXL[rxc];
    assign txl = TXL[txc];
    assign rx_lvl = en ? rxn >= rxl : rxn != CNT_ZERO;
    assign tx_in = acc && pwrite && paddr == OFF_DATA && txn < lim;
    assign tx_out = tx_pop && tx_char.valid;
    assign rx_in = rx_char.valid && rxn < lim;
    assign rx_out = acc && !pwrite && paddr == OFF_DATA && rxn != CNT_ZERO;
    // shadow of the control fields, kept only when enable is written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {rxc, txc, dma, en} <= 6'h00;
        end else if (fw) begin
            en <= pwdata[0];
            if (pwdata[0]) begin
                {rxc, txc, dma} <= pwdata[7:3];
            end
        end
    end
    // shadow fill counts, flushed only with enable set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txn <= CNT_ZERO;
            rxn <= CNT_ZERO;
        end else begin
            txn <= (fw && pwdata[0] && pwdata[2]) ? CNT_ZERO : txn + 6'(tx_in) - 6'(tx_out);
            rxn <= (fw && pwdata[0] && pwdata[1]) ? CNT_ZERO : rxn + 6'(rx_in) - 6'(rx_out);
        end
    end
    default clocking mon_cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence tx_load_s;
        acc && pwrite && paddr == OFF_DATA && m0 && !tx_pop;
    endsequence
    sequence tx_drop_s;
        en && $past(txn) >= txl && txn < txl;
    endsequence
    tx_empty_a: assert property (m0 && txn == CNT_ZERO |=> !tx_dma_ready_n)
        else $error("tx ready high while empty");
    tx_load_a: assert property (tx_load_s |-> ##2 tx_dma_ready_n)
        else $error("tx ready low after load");
    rx_mode0_a: assert property (m0 |=> rx_dma_ready_n == $past(rxn == CNT_ZERO))
        else $error("rx ready wrong in mode 0");
    tx_trig_a: assert property (en && dma && txn <= txl |=> !tx_dma_ready_n)
        else $error("tx ready high at trigger");
    rx_trig_a: assert property (en && dma && rxn >= rxl |=> !rx_dma_ready_n)
        else $error("rx ready high at trigger");
    rx_irq_a: assert property (1'b1 |=> rx_irq_req == $past(rx_lvl))
        else $error("rx request wrong");
    tx_below_a: assert property (tx_drop_s |-> ##[1:3] tx_irq_req)
        else $error("tx request missing");
    isr_clear_a: assert property (isr_rd && !tx_pop && !$past(tx_pop) |=> !tx_irq_req)
        else $error("tx request not cleared");
    reset_val_a: assert property ($rose(presetn) |-> rx_dma_ready_n && !tx_irq_req)
        else $error("wrong value after reset");
endmodule
bind uart_fifo_dma_control uart_fifo_monitor mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .tx_pop(tx_pop), .tx_char(tx_char), .rx_char(rx_char),
    .tx_dma_ready_n(tx_dma_ready_n), .rx_dma_ready_n(rx_dma_ready_n),
    .tx_irq_req(tx_irq_req), .rx_irq_req(rx_irq_req));

// *** uart_line_model.sv ***
// serial side model: drains tx characters and feeds rx characters
// assumes the bench calls its tasks after reset
`timescale 1ns/100ps
module uart_line_model
    import uart_fifo_pkg::*;
(
    // clock
    input wire logic pclk,
    // transmit side
    input wire uart_fifo_pkg::char_t tx_char,
    output logic tx_pop,
    // receive side
    output uart_fifo_pkg::char_t rx_char
);
    logic [7:0] next_rx = 8'h00;
    logic [7:0] last_tx = 8'h00;
    // idle strobes at time zero
    initial begin
        tx_pop = 1'b0;
        rx_char = CHAR_NONE;
    end
    // take n characters, at least two cycles apart
    task automatic pop_n(input int n);
        repeat (n) begin
            do @(posedge pclk); while (tx_char.valid !== 1'b1);
            tx_pop <= 1'b1;
            last_tx <= tx_char.data;
            @(posedge pclk);
            tx_pop <= 1'b0;
            @(posedge pclk);
        end
    endtask
    // send n characters; idle data is inverted so it never looks held
    task automatic push_n(input int n);
        repeat (n) begin
            @(posedge pclk);
            rx_char <= {1'b1, next_rx};
            next_rx <= next_rx + 8'h01;
            @(posedge pclk);
            rx_char <= {1'b0, ~next_rx};
        end
    endtask
endmodule

// *** uart_fifo_dma_control_tb.sv ***
// self-checking bench for the uart fifo and dma control block
// assumes the line model and the bound monitor are compiled first
`timescale 1ns/100ps
module uart_fifo_dma_control_tb;
    import uart_fifo_pkg::*;
    localparam int RXL [4] = '{8, 16, 24, 28};
    localparam int TXL [4] = '{16, 8, 24, 30};
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, rx_timeout, err_seen;
    logic tx_pop, tx_dma_ready_n, rx_dma_ready_n, tx_irq_req, rx_irq_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    char_t tx_char, rx_char;
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0;
    // design and serial side
    uart_fifo_dma_control uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_pop(tx_pop), .tx_char(tx_char), .rx_char(rx_char),
        .rx_timeout(rx_timeout), .tx_dma_ready_n(tx_dma_ready_n),
        .rx_dma_ready_n(rx_dma_ready_n), .tx_irq_req(tx_irq_req), .rx_irq_req(rx_irq_req));
    uart_line_model line (.pclk(pclk), .tx_char(tx_char), .tx_pop(tx_pop), .rx_char(rx_char));
    // 10 mhz clock
    always #50 pclk = ~pclk;
    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            wrap_up();
        end
    end
    // counts and verdict
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // one comparison
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // let n edges pass, then settle
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    // fifo off: holding registers drive the ready lines
    task automatic t_mode0();
        logic [7:0] b;
        cyc(2);
        chk("tx_rdy", tx_dma_ready_n, 32'h0);
        chk("rx_rdy", rx_dma_ready_n, 32'h1);
        apb(1'b0, OFF_FIFO_CONTROL, 32'h0);
        chk("fcr", rd, 32'h0);
        apb(1'b0, OFF_INT_STATUS, 32'h0);
        chk("isr", rd, 32'h1);
        apb(1'b1, OFF_DATA, 32'h5A);
        cyc(2);
        chk("tx_rdy", tx_dma_ready_n, 32'h1);
        line.pop_n(1);
        cyc(3);
        chk("tx_byte", line.last_tx, 32'h5A);
        chk("tx_rdy", tx_dma_ready_n, 32'h0);
        b = line.next_rx;
        line.push_n(1);
        cyc(2);
        chk("rx_rdy", rx_dma_ready_n, 32'h0);
        apb(1'b0, OFF_DATA, 32'h0);
        chk("rx_byte", rd, b);
        cyc(2);
        chk("rx_rdy", rx_dma_ready_n, 32'h1);
    endtask
    // field writes need the enable bit; unmapped address refused
    task automatic t_fields();
        apb(1'b1, OFF_FIFO_CONTROL, 32'hF9);
        apb(1'b0, OFF_FIFO_CONTROL, 32'h0);
        chk("fcr", rd, 32'hF9);
        apb(1'b1, OFF_FIFO_CONTROL, 32'h36);
        apb(1'b0, OFF_FIFO_CONTROL, 32'h0);
        chk("fcr", rd, 32'hF8);
        apb(1'b1, OFF_FIFO_CONTROL, 32'h01);
        line.push_n(2);
        cyc(2);
        chk("tx_rdy", tx_dma_ready_n, 32'h0);
        chk("rx_rdy", rx_dma_ready_n, 32'h0);
        apb(1'b1, OFF_DATA, 32'hA5);
        cyc(2);
        chk("tx_rdy", tx_dma_ready_n, 32'h1);
        apb(1'b0, OFF_INT_STATUS, 32'h0);
        chk("isr_en", rd & 32'hC0, 32'hC0);
        apb(1'b0, 12'h010, 32'h0);
        chk("slverr", err_seen, 32'h1);
    endtask
    // mode 1 receive: timeout, trigger, overfill, drain, flush
    task automatic t_rx(input int c);
        int l;
        l = RXL[c];
        apb(1'b1, OFF_FIFO_CONTROL, 32'(c << 6) | 32'h0B);
        line.push_n(1);
        cyc(2);
        chk("rx_rdy", rx_dma_ready_n, 32'h1);
        @(posedge pclk);
        rx_timeout <= 1'b1;
        @(posedge pclk);
        rx_timeout <= 1'b0;
        cyc(2);
        chk("rx_rdy", rx_dma_ready_n, 32'h0);
        line.push_n(l - 2);
        cyc(2);
        chk("rx_irq", rx_irq_req, 32'h0);
        line.push_n(1);
        cyc(2);
        chk("rx_irq", rx_irq_req, 32'h1);
        line.push_n(33 - l);
        apb(1'b0, OFF_FIFO_STATUS, 32'h0);
        chk("rx_fill", rd[16:8], 32'h120);
        repeat (33 - l) apb(1'b0, OFF_DATA, 32'h0);
        cyc(2);
        chk("rx_irq", rx_irq_req, 32'h0);
        chk("rx_rdy", rx_dma_ready_n, 32'h0);
        apb(1'b1, OFF_FIFO_CONTROL, 32'(c << 6) | 32'h0B);
        apb(1'b0, OFF_FIFO_STATUS, 32'h0);
        chk("rx_fill", rd[13:8], 32'h0);
        chk("rx_rdy", rx_dma_ready_n, 32'h1);
    endtask
    // mode 1 transmit: fill to full, drain to and below trigger
    task automatic t_tx(input int c);
        int l;
        l = TXL[c];
        apb(1'b1, OFF_FIFO_CONTROL, 32'(c << 4) | 32'h0D);
        apb(1'b0, OFF_INT_STATUS, 32'h0);
        cyc(2);
        chk("tx_irq", tx_irq_req, 32'h0);
        for (int i = 0; i < 32; i++) apb(1'b1, OFF_DATA, 32'(i));
        cyc(2);
        chk("tx_rdy", tx_dma_ready_n, 32'h1);
        apb(1'b0, OFF_FIFO_STATUS, 32'h0);
        chk("tx_fill", rd[5:0], 32'h20);
        line.pop_n(32 - l);
        cyc(3);
        chk("tx_byte", line.last_tx, 32'(31 - l));
        chk("tx_irq", tx_irq_req, 32'h0);
        chk("tx_rdy", tx_dma_ready_n, 32'h0);
        line.pop_n(1);
        cyc(3);
        chk("tx_irq", tx_irq_req, 32'h1);
        apb(1'b0, OFF_INT_STATUS, 32'h0);
        chk("isr_tx", rd[0], 32'h1);
        cyc(1);
        chk("tx_irq", tx_irq_req, 32'h0);
        apb(1'b1, OFF_FIFO_CONTROL, 32'(c << 4) | 32'h0D);
        apb(1'b0, OFF_FIFO_STATUS, 32'h0);
        chk("tx_fill", rd[5:0], 32'h0);
    endtask
    // reset, then the scenarios
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, rx_timeout} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_mode0();
        t_fields();
        for (int c = 0; c < 4; c++) begin
            t_rx(c);
            t_tx(c);
        end
        wrap_up();
    end
endmodule
